// [commission_consts.svh]
// Constants of the pushbutton commissioning controller
`ifndef COMMISSION_CONSTS_SVH
`define COMMISSION_CONSTS_SVH

// Press timing, in milliseconds, and the clock rate
`define CLK_HZ 100_000_000
`define LONG_PRESS_MS 7000
`define SHORT_PRESS_MS 2000
`define MS_CYCLES (`CLK_HZ / 1000)

// Radio channels
`define CHAN_FIRST 5'h0B
`define CHAN_LAST 5'h1A

// Fixed payload bytes and the payload length in bytes
`define CTRL_BYTE 8'h0C
`define CMD_COMMISSION 8'hE0
`define DEV_TYPE_SWITCH 8'h02
`define PAYLOAD_LEN 6'h21

`endif

// [commission_pkg.sv]
// Types of the pushbutton commissioning controller
package commission_pkg;

   // Entry detector progress, Gray coded along the long-short-long path
   typedef enum logic [1:0] {
      ENTRY_IDLE = 2'b00,
      ENTRY_LONG1 = 2'b01,
      ENTRY_SHORT = 2'b11,
      ENTRY_LONG2 = 2'b10
   } entry_state_t;

endpackage

// [commission_fifo.sv]
// The telegram byte FIFO module stands beside the controller module

// [pushbutton_commissioning_ctrl.sv]
// Commissioning controller: press sequence, channel, telegram stream
//
// Functional notes
// - Any contact may be chosen; all three presses must use it.
// - On full sequence enter commissioning mode and send one telegram.
// - Short presses on two different contacts force data mode, drop progress.
// - Channel is 11 after power-up.
// - Channel changes only in commissioning; first short press sets 11.
// - Further short presses advance channel; 26 wraps to 11.
// - Each new channel selection sends a commissioning telegram.
// - Payload: control, id, command, type, options, key, check, counter.
// - Control byte is 0x0C.
// - Command byte is 0xE0.
// - Device type 0x02, then two-byte fixed options code.
// - Key sent encrypted only, then four-byte validation value.
// - Source id and counter go least significant byte first.
// - Current, ever-increasing sequence counter is carried in the telegram.
`timescale 1ns/10ps
`include "commission_consts.svh"
module pushbutton_commissioning_ctrl
   import commission_pkg::*;
#(
   parameter int LONG_CYCLES = `LONG_PRESS_MS * `MS_CYCLES,
   parameter int SHORT_CYCLES = `SHORT_PRESS_MS * `MS_CYCLES,
   parameter logic [15:0] DEVICE_OPTIONS = 16'h0000, // Arbitrary value
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Contacts and energy bar, asynchronous pins
   input wire logic contact_left_lower,
   input wire logic contact_left_upper,
   input wire logic contact_right_lower,
   input wire logic contact_right_upper,
   input wire logic energy_bar,
   // Device identity and security material
   input wire logic [31:0] source_id,
   input wire logic [127:0] encrypted_key,
   input wire logic [31:0] key_check,
   input wire logic [31:0] seq_counter,
   // Status
   output logic commission_mode,
   output logic [4:0] radio_channel,
   output logic telegram_busy,
   // Telegram byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_first,
   output logic [4:0] tx_channel
);

   localparam int CW = 32;

   // Refuse thresholds the press classifier cannot order
   if (SHORT_CYCLES < 1 || LONG_CYCLES <= SHORT_CYCLES) begin : g_bad_press
      $error("Press thresholds must satisfy 0 < short < long");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic bar_s1;
      logic bar_s2;
      logic [3:0] held_reg;
      logic [3:0] press_set;
      logic [CW-1:0] press_cnt;
      entry_state_t entry;
      logic [3:0] selected_contact;
      logic [3:0] last_short;
      logic commission;
      logic first_adjust;
      logic [4:0] channel;
      logic sending;
      logic [5:0] byte_idx;
      logic [4:0] send_chan;
      logic [31:0] lat_id;
      logic [31:0] lat_cnt;
   } ctrl_state_t;

   ctrl_state_t state_reg;
   ctrl_state_t state_next;
   logic [3:0] pins_raw;
   logic [3:0] held;
   logic release_evt;
   logic is_long;
   logic is_short;
   logic one_hot;
   logic [7:0] payload_byte;
   logic start_send;
   logic fifo_ready;

   assign pins_raw = {contact_right_upper, contact_right_lower,
      contact_left_upper, contact_left_lower};
   // A contact counts only together with the energy bar
   assign held = state_reg.pin_s2[3:0] & {4{state_reg.bar_s2}};

   // Press classification at release of all contacts
   assign release_evt = (state_reg.held_reg != 4'h0) && (held == 4'h0);
   assign is_long = state_reg.press_cnt > CW'(LONG_CYCLES);
   assign is_short = state_reg.press_cnt < CW'(SHORT_CYCLES);
   assign one_hot = $onehot(state_reg.press_set);

   // ------------------------------------------------------------
   // Payload byte selection
   // ------------------------------------------------------------
   always_comb begin
      payload_byte = 8'h00;
      case (state_reg.byte_idx)
         6'd0: payload_byte = `CTRL_BYTE;
         6'd1: payload_byte = state_reg.lat_id[7:0];
         6'd2: payload_byte = state_reg.lat_id[15:8];
         6'd3: payload_byte = state_reg.lat_id[23:16];
         6'd4: payload_byte = state_reg.lat_id[31:24];
         6'd5: payload_byte = `CMD_COMMISSION;
         6'd6: payload_byte = `DEV_TYPE_SWITCH;
         6'd7: payload_byte = DEVICE_OPTIONS[7:0];
         6'd8: payload_byte = DEVICE_OPTIONS[15:8];
         default: begin
            if (state_reg.byte_idx < 6'd25) begin
               payload_byte = encrypted_key[8*(state_reg.byte_idx - 6'd9)
                  +: 8];
            end else if (state_reg.byte_idx < 6'd29) begin
               payload_byte = key_check[8*(state_reg.byte_idx - 6'd25)
                  +: 8];
            end else begin
               payload_byte = state_reg.lat_cnt[8*(state_reg.byte_idx
                  - 6'd29) +: 8];
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      start_send = 1'b0;
      state_next.pin_s1 = pins_raw;
      state_next.pin_s2 = state_reg.pin_s1;
      // Energy bar passes the same two-stage synchroniser
      state_next.bar_s1 = energy_bar;
      state_next.bar_s2 = state_reg.bar_s1;
      state_next.held_reg = held;

      // Press timer runs while any contact is held
      if (held != 4'h0) begin
         state_next.press_set = state_reg.press_set | held;
         if (state_reg.press_cnt != '1) begin
            state_next.press_cnt = state_reg.press_cnt + 1'b1;
         end
      end

      if (release_evt) begin
         state_next.press_cnt = '0;
         state_next.press_set = 4'h0;
         // Two short presses on different contacts
         if (!is_long && one_hot && state_reg.last_short != 4'h0
               && state_reg.last_short != state_reg.press_set) begin
            state_next.commission = 1'b0;
            state_next.entry = ENTRY_IDLE;
            state_next.last_short = 4'h0;
         end else begin
            state_next.last_short = (!is_long && one_hot) ?
               state_reg.press_set : 4'h0;
            if (state_reg.commission) begin
               if (!is_long && state_reg.press_set
                     == state_reg.selected_contact) begin
                  if (state_reg.first_adjust) begin
                     state_next.channel = `CHAN_FIRST;
                     state_next.first_adjust = 1'b0;
                  end else if (state_reg.channel == `CHAN_LAST) begin
                     state_next.channel = `CHAN_FIRST;
                  end else begin
                     state_next.channel = state_reg.channel + 1'b1;
                  end
                  start_send = 1'b1;
               end
            end else begin
               case (state_reg.entry)
                  ENTRY_IDLE: begin
                     if (is_long && one_hot) begin
                        state_next.entry = ENTRY_LONG1;
                        state_next.selected_contact = state_reg.press_set;
                     end
                  end
                  ENTRY_LONG1: begin
                     if (state_reg.press_set != state_reg.selected_contact)
                        begin
                        state_next.entry = ENTRY_IDLE;
                     end else if (is_short) begin
                        state_next.entry = ENTRY_SHORT;
                     end else if (!is_long) begin
                        state_next.entry = ENTRY_IDLE;
                     end
                  end
                  ENTRY_SHORT: begin
                     if (is_long && state_reg.press_set
                           == state_reg.selected_contact) begin
                        state_next.entry = ENTRY_IDLE;
                        state_next.commission = 1'b1;
                        state_next.first_adjust = 1'b1;
                        start_send = 1'b1;
                     end else if (is_long && one_hot) begin
                        state_next.entry = ENTRY_LONG1;
                        state_next.selected_contact = state_reg.press_set;
                     end else begin
                        state_next.entry = ENTRY_IDLE;
                     end
                  end
                  default: state_next.entry = ENTRY_IDLE;
               endcase
            end
         end
      end

      // Telegram serialiser; a new request restarts the stream
      if (start_send) begin
         state_next.sending = 1'b1;
         state_next.byte_idx = 6'd0;
         state_next.send_chan = state_next.channel;
         state_next.lat_id = source_id;
         state_next.lat_cnt = seq_counter;
      end else if (state_reg.sending && fifo_ready) begin
         if (state_reg.byte_idx == `PAYLOAD_LEN - 6'd1) begin
            state_next.sending = 1'b0;
         end else begin
            state_next.byte_idx = state_reg.byte_idx + 1'b1;
         end
      end
   end

   // Register update
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_reg <= '0;
         state_reg.entry <= ENTRY_IDLE;
         state_reg.channel <= `CHAN_FIRST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Output FIFO; stalls the serialiser when the radio lags
   // ------------------------------------------------------------
   logic [13:0] fifo_out;
   commission_fifo #(
      .WIDTH(14),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_valid(state_reg.sending),
      .in_ready(fifo_ready),
      .in_data({state_reg.send_chan, state_reg.byte_idx == 6'd0,
         payload_byte}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(fifo_out)
   );

   assign tx_data = fifo_out[7:0];
   assign tx_first = fifo_out[8];
   assign tx_channel = fifo_out[13:9];
   assign commission_mode = state_reg.commission;
   assign radio_channel = state_reg.channel;
   assign telegram_busy = state_reg.sending;

endmodule // pushbutton_commissioning_ctrl

// ------------------------------------------------------------
// Telegram byte FIFO
// ------------------------------------------------------------
module commission_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer arithmetic relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } fifo_state_t;

   fifo_state_t state_reg;
   fifo_state_t state_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;

   // Full when pointers differ only in the wrap bit
   assign empty = state_reg.wr_ptr == state_reg.rd_ptr;
   assign full = (state_reg.wr_ptr[AW-1:0] == state_reg.rd_ptr[AW-1:0])
      && (state_reg.wr_ptr[AW] != state_reg.rd_ptr[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[state_reg.rd_ptr[AW-1:0]];

   // Pointer update
   always_comb begin
      state_next = state_reg;
      if (in_valid && !full) begin
         state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
         state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
      end
   end

   // Pointer registers
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge sys_clk) begin
      if (in_valid && !full) begin
         mem[state_reg.wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule // commission_fifo

// [commission_chk.sv]
// Port checker of the pushbutton commissioning controller
`timescale 1ns/10ps
module commission_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Status
   input wire logic commission_mode,
   input wire logic [4:0] radio_channel,
   input wire logic telegram_busy,
   // Byte stream
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_first,
   input wire logic [4:0] tx_channel
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Serialiser picks up a telegram within two edges
   sequence s_tel_start;
      ##[0:2] telegram_busy;
   endsequence
   // Reset is checked while it is applied, so no disable
   a_reset_state: assert property (disable iff (1'b0)
      !rstn |=> !commission_mode && radio_channel == 5'h0B && !tx_valid)
      else $error("state not cleared by reset");
   a_chan_range: assert property (
      radio_channel >= 5'h0B && radio_channel <= 5'h1A)
      else $error("channel out of range");
   a_chan_in_mode: assert property (
      $changed(radio_channel) |-> $past(commission_mode))
      else $error("channel changed outside commissioning");
   a_chan_step: assert property (
      $changed(radio_channel) |-> radio_channel == 5'h0B ||
         radio_channel == $past(radio_channel) + 5'h01)
      else $error("channel step wrong");
   a_entry_sends: assert property (
      $rose(commission_mode) |-> s_tel_start)
      else $error("no telegram on entry");
   a_chan_sends: assert property (
      $changed(radio_channel) |-> s_tel_start)
      else $error("no telegram on channel change");
   a_first_ctrl: assert property (
      tx_valid && tx_first |-> tx_data == 8'h0C)
      else $error("first byte not control");
   a_stream_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) &&
         $stable(tx_first) && $stable(tx_channel))
      else $error("stalled byte not held");
endmodule // commission_chk

bind pushbutton_commissioning_ctrl commission_chk u_chk (.sys_clk, .rstn,
   .commission_mode, .radio_channel, .telegram_busy, .tx_valid,
   .tx_ready, .tx_data, .tx_first, .tx_channel);

// [tel_sink.sv]
// Receiver model that takes the telegram byte stream
`timescale 1ns/10ps
module tel_sink (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Stall control
   input wire logic slow,
   // Byte stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_first,
   input wire logic [4:0] tx_channel
);
   logic [7:0] got [0:32];
   logic [4:0] chan;
   int idx = 0;
   int tel_count = 0;
   initial tx_ready = 1'b0;
   // Stalls every other cycle when slow, to exercise the FIFO
   always @(posedge sys_clk) begin
      tx_ready <= rstn && (!slow || !tx_ready);
   end
   // bytes collected in order, byte 0 marked first
   always @(posedge sys_clk) begin
      if (rstn && tx_valid && tx_ready) begin
         if (tx_first) begin
            idx = 0;
            chan = tx_channel;
         end
         if (idx < 33) got[idx] = tx_data;
         idx++;
         if (idx == 33) tel_count++;
      end
   end
endmodule // tel_sink

// [pushbutton_commissioning_ctrl_tb_top.sv]
// Testbench of the pushbutton commissioning controller
`timescale 1ns/10ps
module pushbutton_commissioning_ctrl_tb_top;
   localparam int L = 60;
   localparam logic [15:0] OPTS = 16'hA55A; // Arbitrary value
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] ct = 4'h0;
   logic bar = 1'b0;
   logic slow = 1'b0;
   logic [31:0] sid = 32'h1234_5678; // Arbitrary value
   logic [127:0] key = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
   logic [31:0] kchk = 32'hDEAD_BEEF;
   logic [31:0] seq = 32'h0000_0027;
   logic mode, busy, tx_valid, tx_ready, tx_first;
   logic [4:0] chan, tx_channel;
   logic [7:0] tx_data;
   int mismatches = 0;
   int cmp_count = 0;
   int tels = 0;
   int e;
   always #5 sys_clk = ~sys_clk;
   // Short count 10, long count 40 keep the run brief
   pushbutton_commissioning_ctrl #(.LONG_CYCLES(40), .SHORT_CYCLES(10),
      .DEVICE_OPTIONS(OPTS)) uut (.sys_clk, .rstn,
      .contact_left_lower(ct[0]), .contact_left_upper(ct[1]),
      .contact_right_lower(ct[2]), .contact_right_upper(ct[3]),
      .energy_bar(bar), .source_id(sid), .encrypted_key(key),
      .key_check(kchk), .seq_counter(seq), .commission_mode(mode),
      .radio_channel(chan), .telegram_busy(busy), .tx_valid, .tx_ready,
      .tx_data, .tx_first, .tx_channel);
   tel_sink sink (.sys_clk, .rstn, .slow, .tx_valid, .tx_ready, .tx_data,
      .tx_first, .tx_channel);
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One press with the energy bar, then a quiet gap for the sync chain
   task automatic press(input int c, input int n);
      @(negedge sys_clk);
      ct[c] = 1'b1;
      bar = 1'b1;
      repeat (n) @(negedge sys_clk);
      ct = 4'h0;
      bar = 1'b0;
      repeat (12) @(negedge sys_clk);
   endtask
   function automatic logic [7:0] exp_byte(input int k);
      if (k == 0) return 8'h0C;
      if (k < 5) return sid[8*(k-1) +: 8];
      if (k == 5) return 8'hE0;
      if (k == 6) return 8'h02;
      if (k < 9) return OPTS[8*(k-7) +: 8];
      if (k < 25) return key[8*(k-9) +: 8];
      if (k < 29) return kchk[8*(k-25) +: 8];
      return seq[8*(k-29) +: 8];
   endfunction
   // Waits for a whole telegram, then compares all 33 bytes
   task automatic tel(input logic [4:0] ch);
      int n;
      tels++;
      n = 0;
      while (sink.tel_count < tels && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      check(sink.tel_count, tels);
      check(sink.chan, ch);
      for (int k = 0; k < 33; k++)
         check(sink.got[k], exp_byte(k));
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      rstn = 1'b1;
      check(mode, 0);
      check(chan, 5'h0B);
      // Wrong contact on the last long press
      press(0, L);
      press(0, 5);
      press(1, L);
      check(mode, 0);
      // Middle-length press after the short one restarts entry
      press(0, L);
      press(0, L);
      press(0, 5);
      press(0, 20);
      press(0, L);
      check(mode, 0);
      // Two shorts on different contacts, then a fresh first long
      press(0, 5);
      press(2, 5);
      press(3, 5);
      press(1, L);
      check(mode, 0);
      // Second long on the first step keeps the sequence armed
      press(1, L);
      press(1, 5);
      press(1, L);
      tel(5'h0B);
      check(mode, 1);
      press(1, 5);
      tel(5'h0B);
      slow = 1'b1;
      for (int i = 0; i < 20; i++) begin
         e = (i < 15) ? 12 + i : i - 4;
         press(1, 5);
         tel(e[4:0]);
      end
      slow = 1'b0;
      press(1, L);
      press(0, 5);
      press(2, 5);
      check(chan, 5'h0F);
      check(mode, 0);
      press(1, 5);
      check(chan, 5'h0F);
      seq = seq + 32'h0000_0001;
      press(2, L);
      press(2, 5);
      press(2, L);
      tel(5'h0F);
      press(2, 5);
      tel(5'h0B);
      end_of_test();
   end
   // Watchdog well beyond the expected length of the run
   initial begin
      repeat (30000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
endmodule // pushbutton_commissioning_ctrl_tb_top
